/* File: flow_pkg.sv */
// Purpose: shared constants and types for the control-flow execution unit
// Assumes: 8-bit data, 16-bit program counter, one clock
// Notes: clock counts are in core clocks, one per ref_clk cycle
package flow_pkg;

  // Operation codes presented by the instruction front end
  typedef enum logic [4:0] {
    OP_IDLE_INSTR = 5'h00,
    OP_BR_CARRY = 5'h01,
    OP_BR_NO_CARRY = 5'h02,
    OP_BR_ZERO = 5'h03,
    OP_BR_NOT_ZERO = 5'h04,
    OP_BIT_SET_MEM = 5'h05,
    OP_BIT_SET_ACC = 5'h06,
    OP_BIT_CLR_MEM = 5'h07,
    OP_BIT_CLR_ACC = 5'h08,
    OP_DEC_B = 5'h09,
    OP_DEC_C = 5'h0A,
    OP_DEC_MEM = 5'h0B,
    OP_IRQ_UNMASK = 5'h0C,
    OP_IRQ_MASK = 5'h0D,
    OP_STANDBY_IDLE = 5'h0E,
    OP_STANDBY_STOP = 5'h0F
  } flow_op_t;

  // Instruction lengths in bytes
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [15:0] LEN_4 = 16'h0004;

  // Execution times in core clocks
  localparam logic [3:0] CLK_2 = 4'h2;
  localparam logic [3:0] CLK_6 = 4'h6;
  localparam logic [3:0] CLK_8 = 4'h8;
  localparam logic [3:0] CLK_10 = 4'hA;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Unit states
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_BUSY = 2'b01,
    ST_STANDBY = 2'b10
  } flow_state_t;

endpackage : flow_pkg

/* File: flow_cycle_timer.sv */
// Purpose: counts out the clocks an instruction occupies
// Assumes: load only while idle
// Notes: done pulses in the last clock of the instruction
`timescale 1ns/1ps
module flow_cycle_timer
  import flow_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] cycles,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_q;

  // Load with length minus one so a 2-clock op ends one clock after load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= cycles - WIDTH'(1);
    end else if (count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  assign busy = (count_q != '0);
  assign done = (count_q == WIDTH'(1));

endmodule : flow_cycle_timer

/* File: flow_control_unit.sv */
// Purpose: executes branch, loop, interrupt-control and standby instructions
// Assumes: front end decodes the opcode and supplies operand values
// Notes: flags Z and CY are inputs only, never written here
`timescale 1ns/1ps
module flow_control_unit
  import flow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire flow_op_t issue_op,
  input wire logic [7:0] relative_offset,
  input wire logic [2:0] bit_select,
  input wire logic [7:0] bit_operand,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] mem_operand,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic wake,
  output logic issue_ready,
  output logic [15:0] pc,
  output logic [7:0] reg_b,
  output logic [7:0] reg_c,
  output logic mem_wr,
  output logic [7:0] mem_wr_data,
  output logic interrupt_enable_flag,
  output logic idle_mode,
  output logic stop_mode,
  output logic flags_write,
  output logic retire
);

  flow_state_t state_q, state_d;
  flow_op_t op_q;
  logic [15:0] pc_q, pc_d;
  logic [7:0] b_q, b_d;
  logic [7:0] c_q, c_d;
  logic ie_q, ie_d;
  logic idle_q, stop_q;
  logic mem_wr_q;
  logic [7:0] mem_data_q;
  logic taken_q;
  logic [15:0] len_q;
  // Offset kept from issue; the port may move on while the op runs
  logic [7:0] relative_offset_q;
  // Last clock of a busy instruction
  logic finishing;

  // Decode outputs for the issued instruction
  logic [15:0] op_len;
  logic [3:0] op_clk;
  logic op_taken;
  logic [7:0] dec_b, dec_c, dec_mem;
  logic sel_acc_bit, sel_mem_bit;
  logic start;
  logic timer_busy, timer_done;

  // Bit pick shared by both bit tests
  function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] s);
    pick_bit = v[s];
  endfunction : pick_bit

  // Signed offset widened to pc width
  function automatic logic [15:0] sext_offset(input logic [7:0] d);
    sext_offset = {{8{d[7]}}, d};
  endfunction : sext_offset

  // Either standby op, checked at retirement
  function automatic logic is_standby(input flow_op_t o);
    is_standby = (o == OP_STANDBY_IDLE) || (o == OP_STANDBY_STOP);
  endfunction : is_standby

  assign start = issue_valid && issue_ready;
  assign finishing = (state_q == ST_BUSY) && timer_done;
  assign sel_acc_bit = pick_bit(accumulator, bit_select);
  assign sel_mem_bit = pick_bit(bit_operand, bit_select);
  // Decremented values feed both the taken test and the write-back
  assign dec_b = b_q - 8'h01;
  assign dec_c = c_q - 8'h01;
  assign dec_mem = mem_operand - 8'h01;

  // Length, duration and branch decision per opcode
  always_comb begin
    op_len = LEN_1;
    op_clk = CLK_2;
    op_taken = 1'b0;
    case (issue_op)
      // Flag branches, all two bytes and six clocks
      OP_BR_CARRY: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = carry_flag;
      end
      OP_BR_NO_CARRY: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = !carry_flag;
      end
      OP_BR_ZERO: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = zero_flag;
      end
      OP_BR_NOT_ZERO: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = !zero_flag;
      end
      // Bit tests; the accumulator forms are a byte shorter
      OP_BIT_SET_MEM: begin
        op_len = LEN_4;
        op_clk = CLK_10;
        op_taken = sel_mem_bit;
      end
      OP_BIT_SET_ACC: begin
        op_len = LEN_3;
        op_clk = CLK_8;
        op_taken = sel_acc_bit;
      end
      OP_BIT_CLR_MEM: begin
        op_len = LEN_4;
        op_clk = CLK_10;
        op_taken = !sel_mem_bit;
      end
      OP_BIT_CLR_ACC: begin
        op_len = LEN_3;
        op_clk = CLK_8;
        op_taken = !sel_acc_bit;
      end
      // Loops judge the decremented value, not the old one
      OP_DEC_B: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = (dec_b != 8'h00);
      end
      OP_DEC_C: begin
        op_len = LEN_2;
        op_clk = CLK_6;
        op_taken = (dec_c != 8'h00);
      end
      OP_DEC_MEM: begin
        op_len = LEN_3;
        op_clk = CLK_8;
        op_taken = (dec_mem != 8'h00);
      end
      // Control and standby ops never branch
      OP_IRQ_UNMASK, OP_IRQ_MASK: begin
        op_len = LEN_3;
        op_clk = CLK_6;
      end
      OP_IDLE_INSTR, OP_STANDBY_IDLE, OP_STANDBY_STOP: begin
        op_len = LEN_1;
        op_clk = CLK_2;
      end
      // Unused codes behave as a one-byte idle op
      default: begin
        op_len = LEN_1;
        op_clk = CLK_2;
      end
    endcase
  end

  // Clock counter for instruction duration
  // Four bits cover the longest op, ten clocks
  flow_cycle_timer #(.WIDTH(4)) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(start),
    .cycles(op_clk),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Next state; pc and enable-flag effects land at retirement, B and C step at issue
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    b_d = b_q;
    c_d = c_q;
    ie_d = ie_q;
    case (state_q)
      ST_READY: begin
        if (start) begin
          state_d = ST_BUSY;
          // Loop registers step at issue; the branch resolves later
          if (issue_op == OP_DEC_B) b_d = dec_b;
          if (issue_op == OP_DEC_C) c_d = dec_c;
        end
      end
      ST_BUSY: begin
        if (timer_done) begin
          // Target is the following instruction address plus the offset
          pc_d = taken_q ? (pc_q + len_q + sext_offset(relative_offset_q))
                         : (pc_q + len_q);
          // Enable flag changes only as the op completes
          if (op_q == OP_IRQ_UNMASK) ie_d = 1'b1;
          if (op_q == OP_IRQ_MASK) ie_d = 1'b0;
          if (is_standby(op_q)) begin
            state_d = ST_STANDBY;
          end else begin
            state_d = ST_READY;
          end
        end
      end
      ST_STANDBY: begin
        // Wake is a level; held high it just leaves standby at once
        if (wake) state_d = ST_READY;
      end
      default: state_d = ST_READY;
    endcase
  end

  // Capture the issued instruction; operands are held for its duration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_q <= OP_IDLE_INSTR;
      taken_q <= 1'b0;
      len_q <= LEN_1;
      relative_offset_q <= REG_RESET;
    end else if (start) begin
      op_q <= issue_op;
      taken_q <= op_taken;
      len_q <= op_len;
      relative_offset_q <= relative_offset;
    end
  end

  // Architectural state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_READY;
      pc_q <= PC_RESET;
      b_q <= REG_RESET;
      c_q <= REG_RESET;
      ie_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      b_q <= b_d;
      c_q <= c_d;
      ie_q <= ie_d;
    end
  end

  // Memory write-back of a decremented byte, one pulse at issue
  // The front end performs the store; this unit only offers it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr_q <= 1'b0;
      mem_data_q <= REG_RESET;
    end else begin
      mem_wr_q <= start && (issue_op == OP_DEC_MEM);
      if (start && (issue_op == OP_DEC_MEM)) mem_data_q <= dec_mem;
    end
  end

  // Standby mode levels; stop also gates the oscillator outside
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (finishing) begin
      idle_q <= (op_q == OP_STANDBY_IDLE);
      stop_q <= (op_q == OP_STANDBY_STOP);
    end else if (state_q == ST_STANDBY && wake) begin
      // Only wake leaves stop; nothing here restarts the oscillator
      idle_q <= 1'b0;
      stop_q <= 1'b0;
    end
  end

  // Handshake outputs; a load never lands while the timer still counts
  assign issue_ready = (state_q == ST_READY) && !timer_busy;
  assign retire = finishing;
  // Flags are only read here, so the write strobe is tied off
  assign flags_write = 1'b0;

  // Data outputs straight from flip-flops
  assign pc = pc_q;
  assign reg_b = b_q;
  assign reg_c = c_q;
  assign mem_wr = mem_wr_q;
  assign mem_wr_data = mem_data_q;
  assign interrupt_enable_flag = ie_q;
  assign idle_mode = idle_q;
  assign stop_mode = stop_q;

endmodule : flow_control_unit

/* File: flow_control_assertions.sv */
// Purpose: port-level timing and result checks for flow_control_unit
// Assumes: retire is seen N-1 edges after the issue edge of an N-clock op
// Notes: operands are judged as they stood at the issue edge
`timescale 1ns/1ps
module flow_control_assertions
  import flow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire flow_op_t issue_op,
  input wire logic [7:0] relative_offset,
  input wire logic [7:0] mem_operand,
  input wire logic carry_flag,
  input wire logic wake,
  input wire logic issue_ready,
  input wire logic [15:0] pc,
  input wire logic [7:0] reg_b,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wr_data,
  input wire logic stop_mode,
  input wire logic flags_write,
  input wire logic retire
);
  // Accepted issues sorted by clock count
  wire logic acc = issue_valid && issue_ready;
  wire logic c2 = acc && (issue_op inside {OP_IDLE_INSTR, OP_STANDBY_IDLE, OP_STANDBY_STOP});
  wire logic c8 = acc && (issue_op inside {OP_BIT_SET_ACC, OP_BIT_CLR_ACC, OP_DEC_MEM});
  wire logic c10 = acc && (issue_op inside {OP_BIT_SET_MEM, OP_BIT_CLR_MEM});
  wire logic c6 = acc && !c2 && !c8 && !c10;
  wire logic [15:0] off_ext = {{8{relative_offset[7]}}, relative_offset};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_flags_kept: assert property (flags_write == 1'b0)
    else $error("flag write seen");
  a_six_clock: assert property (c6 |=> !retire [*4] ##1 retire)
    else $error("six-clock op retired at wrong time");
  a_eight_clock: assert property (c8 |=> !retire [*6] ##1 retire)
    else $error("eight-clock op retired at wrong time");
  a_ten_clock: assert property (c10 |=> !retire [*8] ##1 retire)
    else $error("ten-clock op retired at wrong time");
  a_two_clock: assert property (c2 |=> retire)
    else $error("two-clock op retired at wrong time");
  a_carry_target: assert property (acc && issue_op == OP_BR_CARRY && carry_flag |-> ##6
    pc == $past(pc, 6) + 16'h0002 + $past(off_ext, 6)) else $error("carry branch target wrong");
  a_idle_advance: assert property (acc && issue_op == OP_IDLE_INSTR |-> ##2
    pc == $past(pc, 2) + 16'h0001) else $error("idle op pc step wrong");
  a_mem_dec: assert property (acc && issue_op == OP_DEC_MEM |=>
    mem_wr && mem_wr_data == $past(mem_operand) - 8'h01) else $error("memory decrement wrong");
  a_b_dec: assert property (acc && issue_op == OP_DEC_B |=>
    reg_b == $past(reg_b) - 8'h01) else $error("register b decrement wrong");
  a_stop_entry: assert property (acc && issue_op == OP_STANDBY_STOP |-> ##2
    stop_mode && !issue_ready) else $error("stop mode not entered");

  // Main scenarios reached
  c_ten: cover property (c10);
  c_mem: cover property (acc && issue_op == OP_DEC_MEM);
  c_wake: cover property (stop_mode && wake);
endmodule : flow_control_assertions

bind flow_control_unit flow_control_assertions chk_u (.ref_clk, .rst, .issue_valid, .issue_op,
  .relative_offset, .mem_operand, .carry_flag, .wake, .issue_ready, .pc, .reg_b, .mem_wr,
  .mem_wr_data, .stop_mode, .flags_write, .retire);

/* File: tb_top.sv */
// Purpose: self-checking bench for flow_control_unit
// Assumes: inputs change on the falling edge only
// Notes: expected pc is tracked here from lengths and offsets
`timescale 1ns/1ps
module tb_top;
  import flow_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  flow_op_t issue_op = OP_IDLE_INSTR;
  logic [7:0] relative_offset = 8'h00, bit_operand = 8'h00, accumulator = 8'h00;
  logic [7:0] mem_operand = 8'h00, reg_b, reg_c, mem_wr_data;
  logic [2:0] bit_select = 3'h0;
  logic carry_flag = 1'b0, zero_flag = 1'b0, wake = 1'b0;
  logic issue_ready, mem_wr, interrupt_enable_flag, idle_mode, stop_mode, flags_write, retire;
  logic [15:0] pc, exp_pc = 16'h0000;
  int num_errors = 0, checks = 0, cyc = 0;

  // Free-running clock, 8 ns
  always #4 ref_clk = ~ref_clk;

  flow_control_unit dut_u (.ref_clk, .rst, .issue_valid, .issue_op, .relative_offset,
    .bit_select, .bit_operand, .accumulator, .mem_operand, .carry_flag, .zero_flag, .wake,
    .issue_ready, .pc, .reg_b, .reg_c, .mem_wr, .mem_wr_data, .interrupt_enable_flag,
    .idle_mode, .stop_mode, .flags_write, .retire);

  task complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One instruction: clock count to retire, then pc after it lands
  task issue(input flow_op_t op, input int n, input logic [15:0] len, input logic tk);
    int k;
    check("ready", 16'(issue_ready), 16'h0001);
    issue_op = op;
    issue_valid = 1'b1;
    @(negedge ref_clk);
    issue_valid = 1'b0;
    k = 1;
    while (retire !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    check("clocks", 16'(k), 16'(n - 1));
    @(negedge ref_clk);
    exp_pc = exp_pc + len + (tk ? {{8{relative_offset[7]}}, relative_offset} : 16'h0000);
    check("pc", pc, exp_pc);
  endtask : issue

  // Other flag set opposite, so a swapped flag test shows
  task t_branches;
    for (int i = 0; i < 4; i++) begin
      carry_flag = i[0];
      zero_flag = ~i[0];
      relative_offset = i[1] ? 8'hFE : 8'h7F;
      for (int j = 1; j <= 4; j++) begin
        issue(flow_op_t'(5'(j)), 6, LEN_2, (j < 3 ? carry_flag : zero_flag) == j[0]);
        check("flags", 16'(flags_write), 16'h0000);
      end
    end
  endtask : t_branches

  task t_bits;
    bit_select = 3'h6;
    relative_offset = 8'h10;
    for (int p = 0; p < 2; p++) begin
      bit_operand = p[0] ? 8'hBF : 8'h40;
      accumulator = ~bit_operand;
      issue(OP_BIT_SET_MEM, 10, LEN_4, !p[0]);
      issue(OP_BIT_SET_ACC, 8, LEN_3, p[0]);
      issue(OP_BIT_CLR_MEM, 10, LEN_4, p[0]);
      issue(OP_BIT_CLR_ACC, 8, LEN_3, !p[0]);
    end
  endtask : t_bits

  // Full wrap of B: only the last pass falls through
  task t_loops;
    relative_offset = 8'hF0;
    for (int i = 256; i > 0; i--) issue(OP_DEC_B, 6, LEN_2, i > 1);
    check("b", 16'(reg_b), 16'h0000);
    check("c", 16'(reg_c), 16'h0000);
    issue(OP_DEC_C, 6, LEN_2, 1'b1);
    check("c", 16'(reg_c), 16'h00FF);
    for (int m = 0; m < 2; m++) begin
      mem_operand = m[0] ? 8'h00 : 8'h01;
      issue(OP_DEC_MEM, 8, LEN_3, m[0]);
      check("mem", 16'(mem_wr_data), m[0] ? 16'h00FF : 16'h0000);
      check("mem_wr", 16'(mem_wr), 16'h0000);
    end
  endtask : t_loops

  task t_irq;
    check("ie", 16'(interrupt_enable_flag), 16'h0000);
    issue(OP_IRQ_UNMASK, 6, LEN_3, 1'b0);
    check("ie", 16'(interrupt_enable_flag), 16'h0001);
    issue(OP_IRQ_MASK, 6, LEN_3, 1'b0);
    check("ie", 16'(interrupt_enable_flag), 16'h0000);
  endtask : t_irq

  // Offers made in standby must be refused until wake
  task t_standby;
    issue(OP_IDLE_INSTR, 2, LEN_1, 1'b0);
    for (int s = 0; s < 2; s++) begin
      issue(s[0] ? OP_STANDBY_STOP : OP_STANDBY_IDLE, 2, LEN_1, 1'b0);
      check("mode", 16'({idle_mode, stop_mode}), s[0] ? 16'h0001 : 16'h0002);
      issue_op = OP_IDLE_INSTR;
      issue_valid = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("ready", 16'(issue_ready), 16'h0000);
      issue_valid = 1'b0;
      check("pc", pc, exp_pc);
      wake = 1'b1;
      @(negedge ref_clk);
      wake = 1'b0;
      @(negedge ref_clk);
      check("mode", 16'({idle_mode, stop_mode}), 16'h0000);
    end
  endtask : t_standby

  // Main sequence
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    check("pc", pc, 16'h0000);
    t_branches();
    t_bits();
    t_loops();
    t_irq();
    t_standby();
    complete_run();
  end

  // Hang guard, about three times the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      complete_run();
    end
  end
endmodule : tb_top
